/* dasu_top.sv */
// Accumulator datapath: two 40-bit accumulators, accumulator-only operations,
// exponent detection for scaling, and sign-mode aware multiplies.
// Driven by the instruction decoder on the core clock; one operation per
// enabled cycle, operands already read from the working register file.
`timescale 1ns/100ps
module dasu_top
  import dasu_pkg::*;
#(
  parameter int ACC_WIDTH  = 40,
  parameter int WORD_WIDTH = 16
) (
  // Clock, reset, enable
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire logic                 i_ce,
  // Operation request
  input  wire logic                 i_op_valid,
  input  wire dasu_op_e             i_op,
  input  wire logic                 i_acc_sel,
  input  wire logic [WORD_W-1:0]    i_word,
  // Shift amount sources
  input  wire logic                 i_shift_use_reg,
  input  wire logic [SHIFT_W-1:0]   i_shift_lit,
  input  wire logic [WORD_W-1:0]    i_shift_reg,
  // Detector operand select
  input  wire logic                 i_exp_byte,
  // Multiply operands and control
  input  wire logic [WORD_W-1:0]    i_core_control_reg,
  input  wire logic [REG_IDX_W-1:0] i_mul_a_idx,
  input  wire logic [REG_IDX_W-1:0] i_mul_b_idx,
  input  wire logic [WORD_W-1:0]    i_mul_a,
  input  wire logic [WORD_W-1:0]    i_mul_b,
  input  wire logic                 i_mul_to_acc,
  // Accumulator state
  output logic      [ACC_W-1:0]     o_accumulator_first,
  output logic      [ACC_W-1:0]     o_accumulator_second,
  // Store result
  output logic      [WORD_W-1:0]    o_store_data,
  output logic                      o_store_valid,
  // Detector result
  output logic      [EXP_W-1:0]     o_exponent,
  output logic                      o_exp_valid,
  // Integer multiply result to the working registers
  output logic      [2*WORD_W-1:0]  o_mul_product,
  output logic                      o_mul_valid
);

  if (ACC_WIDTH != ACC_W || WORD_WIDTH != WORD_W) begin : g_chk
    $error("dasu_top: only 40-bit accumulators and 16-bit words are served");
  end

  typedef struct packed {
    logic [ACC_W-1:0]    acc_first;
    logic [ACC_W-1:0]    acc_second;
    logic [WORD_W-1:0]   store_data;
    logic                store_valid;
    logic [EXP_W-1:0]    exponent;
    logic                exp_valid;
    logic [2*WORD_W-1:0] mul_product;
    logic                mul_valid;
  } dasu_state_s;

  dasu_state_s state_reg;
  dasu_state_s state_next;

  logic [ACC_W-1:0]   acc_sel_val;
  logic [ACC_W-1:0]   acc_oth_val;
  logic [ACC_W-1:0]   acc_result;
  logic               acc_write;
  logic [ACC_W-1:0]   word_hi_ext;
  logic [ACC_W-1:0]   rounded;
  logic [SHIFT_W-1:0] shift_amt;
  logic [SHIFT_W-1:0] shift_mag;
  logic [ACC_W-1:0]   shifted;
  logic [EXP_W-1:0]   exp_byte;
  logic [EXP_W-1:0]   exp_word;
  logic [PROD_W-1:0]  product;
  logic [ACC_W-1:0]   product_ext;

  // Operand selection: each operation reads only the accumulators it names
  assign acc_sel_val = i_acc_sel ? state_reg.acc_second : state_reg.acc_first;
  assign acc_oth_val = i_acc_sel ? state_reg.acc_first  : state_reg.acc_second;

  // Word placed in the high word, sign carried through the 8 guard bits
  assign word_hi_ext = {{GUARD_W{i_word[WORD_W-1]}}, i_word, {HIGH_LSB{1'b0}}};

  // Rounded store adds half a step, then keeps only the high word
  assign rounded = acc_sel_val + ROUND_HALF;

  // Shift amount from literal or from the low bits of a working register
  assign shift_amt = i_shift_use_reg ? i_shift_reg[SHIFT_W-1:0] : i_shift_lit;
  assign shift_mag = shift_amt[SHIFT_W-1] ? SHIFT_W'(-shift_amt) : shift_amt;

  // Negative amounts shift left so a detector result can be used directly
  assign shifted = shift_amt[SHIFT_W-1]
                 ? (acc_sel_val << shift_mag)
                 : ACC_W'($signed(acc_sel_val) >>> shift_mag);

  // Detector on the guard byte width and on the word width
  dasu_exp_detect #(
    .WIDTH (GUARD_W)
  ) u_exp_byte (
    .i_data    (i_word[GUARD_W-1:0]),
    .o_neg_exp (exp_byte)
  );

  dasu_exp_detect #(
    .WIDTH (WORD_W)
  ) u_exp_word (
    .i_data    (i_word),
    .o_neg_exp (exp_word)
  );

  // Multiplier; sign handling follows the core control field
  dasu_mixed_mul u_mul (
    .i_sign_mode (i_core_control_reg[SMODE_MSB:SMODE_LSB]),
    .i_src_a_idx (i_mul_a_idx),
    .i_src_b_idx (i_mul_b_idx),
    .i_a         (i_mul_a),
    .i_b         (i_mul_b),
    .o_product   (product)
  );

  assign product_ext = {{(ACC_W-PROD_W){product[PROD_W-1]}}, product};

  // Accumulator result for the operation in hand
  always_comb begin
    acc_result = acc_sel_val;
    acc_write  = 1'b0;
    if (i_op_valid) begin
      case (i_op)
        DASU_OP_ADD_ACC: begin
          acc_result = acc_sel_val + acc_oth_val;
          acc_write  = 1'b1;
        end
        DASU_OP_SUB_ACC: begin
          acc_result = acc_sel_val - acc_oth_val;
          acc_write  = 1'b1;
        end
        DASU_OP_ADD_WORD: begin
          acc_result = acc_sel_val + word_hi_ext;
          acc_write  = 1'b1;
        end
        DASU_OP_NEGATE: begin
          acc_result = ACC_W'(-acc_sel_val);
          acc_write  = 1'b1;
        end
        DASU_OP_LOAD: begin
          acc_result = word_hi_ext;
          acc_write  = 1'b1;
        end
        DASU_OP_SHIFT: begin
          acc_result = shifted;
          acc_write  = 1'b1;
        end
        DASU_OP_MUL_TO_ACC: begin
          acc_result = product_ext;
          acc_write  = 1'b1;
        end
        DASU_OP_INT_MUL: begin
          acc_result = product_ext;
          acc_write  = i_mul_to_acc;
        end
        default: begin
          acc_result = acc_sel_val;
          acc_write  = 1'b0;
        end
      endcase
    end
  end

  // Next state: only the selected accumulator is ever written
  always_comb begin
    state_next             = state_reg;
    state_next.store_valid = 1'b0;
    state_next.exp_valid   = 1'b0;
    state_next.mul_valid   = 1'b0;
    if (acc_write) begin
      if (i_acc_sel) begin
        state_next.acc_second = acc_result;
      end else begin
        state_next.acc_first = acc_result;
      end
    end
    if (i_op_valid) begin
      case (i_op)
        DASU_OP_STORE: begin
          state_next.store_data  = acc_sel_val[HIGH_MSB:HIGH_LSB];
          state_next.store_valid = 1'b1;
        end
        DASU_OP_STORE_RND: begin
          // Guard bits are never stored, even when in use
          state_next.store_data  = rounded[HIGH_MSB:HIGH_LSB];
          state_next.store_valid = 1'b1;
        end
        DASU_OP_FIND_CHANGE: begin
          state_next.exponent  = i_exp_byte ? exp_byte : exp_word;
          state_next.exp_valid = 1'b1;
        end
        DASU_OP_INT_MUL: begin
          state_next.mul_product = product[2*WORD_W-1:0];
          state_next.mul_valid   = !i_mul_to_acc;
        end
        default: begin
          state_next.store_valid = 1'b0;
        end
      endcase
    end
  end

  // One register stage for all state; enable low freezes everything
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign o_accumulator_first  = state_reg.acc_first;
  assign o_accumulator_second = state_reg.acc_second;
  assign o_store_data         = state_reg.store_data;
  assign o_store_valid        = state_reg.store_valid;
  assign o_exponent           = state_reg.exponent;
  assign o_exp_valid          = state_reg.exp_valid;
  assign o_mul_product        = state_reg.mul_product;
  assign o_mul_valid          = state_reg.mul_valid;

endmodule : dasu_top

/* dasu_pkg.sv */
// Constants, operation codes and field layouts for the accumulator scaling unit.
// Assumes one core clock; operands arrive from the decoder and register file.
// What this block does
// - Add, negate, shift, load, store act on either 40-bit accumulator alone.
// - Accumulators add to or subtract from each other into the selected one.
// - A signed 16-bit word adds into the selected accumulator.
// - Rounded store returns only a 16-bit 1.15 value from the high word.
// - Shift amount comes from an instruction literal or a working register.
// - Negative shift amount shifts left; positive shifts right arithmetically.
// - Detector scans from sign bit down, returns negated exponent of first change.
// - Detector result lies in -15..0; zero means already full scale.
// - All-zeros or all-ones word gives -15, meaning not scalable.
// - Exponent magnitude equals left shift to full scale, e.g. 0x0001 gives -14.
// - Each accumulator carries 8 guard bits above its 32-bit body.
// - Detector takes a guard byte or a high word operand.
// - Normalization uses the 40-bit shift operation with the detected exponent.
// - Mixed-sign multiply mode when sign mode field bits 13:12 hold 10.
// - Mixed mode: registers 4 and 6 unsigned, registers 5 and 7 signed.
// - Mixed mode picks product signedness from the source registers alone.
// - Integer multiply may write its product into either accumulator.
package dasu_pkg;

  localparam int ACC_W      = 40;
  localparam int WORD_W     = 16;
  localparam int GUARD_W    = 8;
  localparam int HIGH_LSB   = 16;
  localparam int HIGH_MSB   = 31;
  localparam int SHIFT_W    = 6;
  localparam int EXP_W      = 5;
  localparam int PROD_W     = 33;
  localparam int REG_IDX_W  = 4;
  localparam int SMODE_LSB  = 12;
  localparam int SMODE_MSB  = 13;

  // Rounding constant: half of one high-word step
  localparam logic [ACC_W-1:0] ROUND_HALF = 40'h0000008000;
  localparam logic [ACC_W-1:0] ACC_RESET  = 40'h0000000000;

  // Multiply sign mode field encodings
  localparam logic [1:0] SMODE_SIGNED   = 2'h0;
  localparam logic [1:0] SMODE_UNSIGNED = 2'h1;
  localparam logic [1:0] SMODE_MIXED    = 2'h2;

  // Working registers that carry an implied signedness in mixed mode
  localparam logic [REG_IDX_W-1:0] WREG_4 = 4'h4;
  localparam logic [REG_IDX_W-1:0] WREG_5 = 4'h5;
  localparam logic [REG_IDX_W-1:0] WREG_6 = 4'h6;
  localparam logic [REG_IDX_W-1:0] WREG_7 = 4'h7;

  typedef enum logic [3:0] {
    DASU_OP_NOP,
    DASU_OP_ADD_ACC,
    DASU_OP_SUB_ACC,
    DASU_OP_ADD_WORD,
    DASU_OP_NEGATE,
    DASU_OP_LOAD,
    DASU_OP_STORE,
    DASU_OP_STORE_RND,
    DASU_OP_SHIFT,
    DASU_OP_MUL_TO_ACC,
    DASU_OP_INT_MUL,
    DASU_OP_FIND_CHANGE
  } dasu_op_e;

endpackage : dasu_pkg

/* dasu_exp_detect.sv */
// Find-first-bit-change-left exponent detector for one operand width.
// Combinational; the caller registers the result.
`timescale 1ns/100ps
module dasu_exp_detect
  import dasu_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Operand
  input  wire logic [WIDTH-1:0] i_data,
  // Negated exponent, two's complement
  output logic      [EXP_W-1:0] o_neg_exp
);

  if (WIDTH < 2 || WIDTH > 16) begin : g_chk
    $error("dasu_exp_detect: WIDTH out of range");
  end

  // Count bits below the sign that match it, stopping at the first change
  always_comb begin
    int  n;
    logic done;
    n    = 0;
    done = 1'b0;
    for (int i = WIDTH - 2; i >= 0; i--) begin
      if (!done && (i_data[i] == i_data[WIDTH-1])) begin
        n = n + 1;
      end else begin
        done = 1'b1;
      end
    end
    // All bits equal gives -(WIDTH-1), i.e. -15 for a word
    o_neg_exp = EXP_W'(-n);
  end

endmodule : dasu_exp_detect

/* dasu_mixed_mul.sv */
// 16x16 multiplier whose operand signedness follows the sign mode field.
// Combinational; the caller registers the product.
`timescale 1ns/100ps
module dasu_mixed_mul
  import dasu_pkg::*;
(
  // Sign mode field and operand source registers
  input  wire logic [1:0]           i_sign_mode,
  input  wire logic [REG_IDX_W-1:0] i_src_a_idx,
  input  wire logic [REG_IDX_W-1:0] i_src_b_idx,
  // Operands
  input  wire logic [WORD_W-1:0]    i_a,
  input  wire logic [WORD_W-1:0]    i_b,
  // Product, 33 bits so every signedness pairing fits
  output logic      [PROD_W-1:0]    o_product
);

  logic               a_signed;
  logic               b_signed;
  logic signed [WORD_W:0]     a_ext;
  logic signed [WORD_W:0]     b_ext;
  logic signed [2*WORD_W+1:0] prod_full;

  // Registers 4 and 6 read unsigned, others signed, in mixed mode
  function automatic logic idx_signed(input logic [REG_IDX_W-1:0] idx);
    idx_signed = !((idx == WREG_4) || (idx == WREG_6));
  endfunction : idx_signed

  // Mode 11 is treated as signed; no behaviour is defined for it
  always_comb begin
    case (i_sign_mode)
      SMODE_UNSIGNED: begin
        a_signed = 1'b0;
        b_signed = 1'b0;
      end
      SMODE_MIXED: begin
        a_signed = idx_signed(i_src_a_idx);
        b_signed = idx_signed(i_src_b_idx);
      end
      default: begin
        a_signed = 1'b1;
        b_signed = 1'b1;
      end
    endcase
  end

  // Extend each operand by one bit so one signed multiplier serves all cases
  assign a_ext     = {a_signed & i_a[WORD_W-1], i_a};
  assign b_ext     = {b_signed & i_b[WORD_W-1], i_b};
  assign prod_full = a_ext * b_ext;
  assign o_product = prod_full[PROD_W-1:0];

endmodule : dasu_mixed_mul

/* dasu_wreg_model.sv */
// Working register file model that stands in for the operand fetch side.
// Assumes the bench writes it on the core clock before any multiply.
`timescale 1ns/100ps
module dasu_wreg_model
  import dasu_pkg::*;
(
  // Clock and write port
  input  wire logic                 i_clk,
  input  wire logic                 i_we,
  input  wire logic [REG_IDX_W-1:0] i_widx,
  input  wire logic [WORD_W-1:0]    i_wdata,
  // Read ports follow the source register numbers
  input  wire logic [REG_IDX_W-1:0] i_a_idx,
  input  wire logic [REG_IDX_W-1:0] i_b_idx,
  output logic      [WORD_W-1:0]    o_a,
  output logic      [WORD_W-1:0]    o_b
);
  logic [WORD_W-1:0] regs [16];

  // Writes land on the edge
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      regs[i_widx] <= i_wdata;
    end
  end

  // Reads settle before the edge, as a fetched operand would
  assign o_a = regs[i_a_idx];
  assign o_b = regs[i_b_idx];
endmodule : dasu_wreg_model

/* dasu_properties.sv */
// Timing checks for the accumulator scaling unit, bound to its top module.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/100ps
module dasu_properties
  import dasu_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_rst,
  input wire logic              i_ce,
  input wire logic              i_op_valid,
  input wire dasu_op_e          i_op,
  input wire logic              i_acc_sel,
  input wire logic [WORD_W-1:0] i_word,
  input wire logic              i_exp_byte,
  input wire logic [ACC_W-1:0]  o_accumulator_first,
  input wire logic [ACC_W-1:0]  o_accumulator_second,
  input wire logic [WORD_W-1:0] o_store_data,
  input wire logic              o_store_valid,
  input wire logic [EXP_W-1:0]  o_exponent,
  input wire logic              o_exp_valid
);
  logic              tk;
  logic [ACC_W-1:0]  lw, sum, dif, rnd;
  logic [WORD_W-1:0] hi1, rhi;

  // Values the next cycle is compared against
  assign tk  = i_ce && i_op_valid;
  assign lw  = {{8{i_word[15]}}, i_word, 16'h0000};
  assign sum = o_accumulator_first + o_accumulator_second;
  assign dif = o_accumulator_first - o_accumulator_second;
  assign rnd = o_accumulator_first + 40'h0000008000;
  assign hi1 = o_accumulator_first[31:16];
  assign rhi = rnd[31:16];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  load_high_word_a: assert property (
    tk && i_op == DASU_OP_LOAD && !i_acc_sel |=> o_accumulator_first == $past(lw))
    else $error("load did not place word in high word");
  add_accs_a: assert property (
    tk && i_op == DASU_OP_ADD_ACC && i_acc_sel |=> o_accumulator_second == $past(sum))
    else $error("accumulator add wrong");
  sub_accs_a: assert property (
    tk && i_op == DASU_OP_SUB_ACC && !i_acc_sel |=> o_accumulator_first == $past(dif))
    else $error("accumulator subtract wrong");
  negate_acc_a: assert property (
    tk && i_op == DASU_OP_NEGATE && !i_acc_sel
    |=> o_accumulator_first == 40'h0000000000 - $past(o_accumulator_first))
    else $error("negate wrong");
  other_acc_hold_a: assert property (
    tk && !i_acc_sel && i_op inside {DASU_OP_LOAD, DASU_OP_NEGATE, DASU_OP_SHIFT,
    DASU_OP_SUB_ACC} |=> $stable(o_accumulator_second))
    else $error("unselected accumulator changed");
  store_high_a: assert property (
    tk && i_op == DASU_OP_STORE && !i_acc_sel |=> o_store_valid && o_store_data == $past(hi1))
    else $error("store word wrong");
  store_round_a: assert property (
    tk && i_op == DASU_OP_STORE_RND && !i_acc_sel
    |=> o_store_valid && o_store_data == $past(rhi))
    else $error("rounded store wrong");
  exp_range_a: assert property (
    o_exp_valid |-> $signed(o_exponent) >= -15 && $signed(o_exponent) <= 0)
    else $error("exponent out of range");
  exp_flat_a: assert property (
    tk && i_op == DASU_OP_FIND_CHANGE && !i_exp_byte
    && (i_word == 16'h0000 || i_word == 16'hFFFF) |=> o_exp_valid && o_exponent == 5'h11)
    else $error("flat word exponent wrong");
endmodule : dasu_properties

bind dasu_top dasu_properties u_props (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_op_valid(i_op_valid), .i_op(i_op), .i_acc_sel(i_acc_sel), .i_word(i_word),
  .i_exp_byte(i_exp_byte), .o_accumulator_first(o_accumulator_first),
  .o_accumulator_second(o_accumulator_second), .o_store_data(o_store_data),
  .o_store_valid(o_store_valid), .o_exponent(o_exponent), .o_exp_valid(o_exp_valid));

/* dasu_top_tb.sv */
// Self-checking bench for the accumulator scaling unit.
// Assumes results show one edge after each accepted operation.
`timescale 1ns/100ps
module dasu_top_tb
  import dasu_pkg::*;
();
  logic i_clk, i_rst, i_ce, i_op_valid, i_acc_sel, i_shift_use_reg, i_exp_byte, i_mul_to_acc;
  dasu_op_e i_op;
  logic [15:0] i_word, i_shift_reg, i_core_control_reg, i_mul_a, i_mul_b, wr_data, st_data;
  logic [5:0]  i_shift_lit;
  logic [3:0]  i_mul_a_idx, i_mul_b_idx, wr_idx;
  logic [39:0] acc1, acc2;
  logic [31:0] prod;
  logic [4:0]  expo;
  logic        wr_en, st_vld, e_vld, m_vld;
  int          error_cnt, total_checks;

  dasu_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_op_valid(i_op_valid),
    .i_op(i_op), .i_acc_sel(i_acc_sel), .i_word(i_word), .i_shift_use_reg(i_shift_use_reg),
    .i_shift_lit(i_shift_lit), .i_shift_reg(i_shift_reg), .i_exp_byte(i_exp_byte),
    .i_core_control_reg(i_core_control_reg), .i_mul_a_idx(i_mul_a_idx),
    .i_mul_b_idx(i_mul_b_idx), .i_mul_a(i_mul_a), .i_mul_b(i_mul_b),
    .i_mul_to_acc(i_mul_to_acc), .o_accumulator_first(acc1), .o_accumulator_second(acc2),
    .o_store_data(st_data), .o_store_valid(st_vld), .o_exponent(expo), .o_exp_valid(e_vld),
    .o_mul_product(prod), .o_mul_valid(m_vld));

  dasu_wreg_model u_wreg (.i_clk(i_clk), .i_we(wr_en), .i_widx(wr_idx), .i_wdata(wr_data),
    .i_a_idx(i_mul_a_idx), .i_b_idx(i_mul_b_idx), .o_a(i_mul_a), .o_b(i_mul_b));

  // 25 MHz core clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [39:0] ex, input logic [39:0] got);
    total_checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Keep leaves the request up so the next call lands back to back
  task automatic go(input dasu_op_e op, input logic sel, input logic [15:0] w, input bit keep);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= op;
    i_acc_sel <= sel;
    i_word <= w;
    if (!keep) begin
      @(posedge i_clk);
      i_op_valid <= 1'b0;
      #1;
    end
  endtask : go

  task automatic shift_src(input logic use_reg, input logic [5:0] lit, input logic [15:0] r);
    @(posedge i_clk);
    i_shift_use_reg <= use_reg;
    i_shift_lit <= lit;
    i_shift_reg <= r;
  endtask : shift_src

  task automatic t_load_store();
    go(DASU_OP_LOAD, 1'b0, 16'h8001, 1'b0);
    chk("acc first", 40'hFF80010000, acc1);
    chk("acc second", 40'h0, acc2);
    go(DASU_OP_STORE, 1'b0, 16'h0000, 1'b0);
    chk("store data", 40'h8001, 40'(st_data));
    chk("store valid", 40'h1, 40'(st_vld));
    go(DASU_OP_LOAD, 1'b1, 16'h1234, 1'b0);
    chk("acc second", 40'h0012340000, acc2);
    $display("Test load_store done");
  endtask : t_load_store

  task automatic t_arith();
    go(DASU_OP_ADD_ACC, 1'b1, 16'h0000, 1'b1);
    go(DASU_OP_SUB_ACC, 1'b0, 16'h0000, 1'b0);
    chk("acc second", 40'hFF80010000 + 40'h0012340000, acc2);
    chk("acc first", 40'hFF80010000 - 40'hFF92350000, acc1);
    go(DASU_OP_NEGATE, 1'b0, 16'h0000, 1'b0);
    chk("acc first", 40'h0012340000, acc1);
    go(DASU_OP_ADD_WORD, 1'b1, 16'hFFFF, 1'b0);
    chk("acc second", 40'hFF92350000 + 40'hFFFFFF0000, acc2);
    $display("Test arith done");
  endtask : t_arith

  // Register source with a decoy literal, then the literal with a decoy register
  task automatic t_shift();
    go(DASU_OP_LOAD, 1'b0, 16'hFF07, 1'b0);
    shift_src(1'b1, 6'h01, 16'hFFF9);
    go(DASU_OP_SHIFT, 1'b0, 16'h0000, 1'b0);
    chk("acc first", 40'hFFFF070000 << 7, acc1);
    go(DASU_OP_STORE, 1'b0, 16'h0000, 1'b0);
    chk("store data", 40'h8380, 40'(st_data));
    go(DASU_OP_LOAD, 1'b0, 16'h0001, 1'b0);
    shift_src(1'b0, 6'h32, 16'h0005);
    go(DASU_OP_SHIFT, 1'b0, 16'h0000, 1'b0);
    chk("acc first", 40'h0040000000, acc1);
    shift_src(1'b0, 6'h0F, 16'h0005);
    go(DASU_OP_SHIFT, 1'b0, 16'h0000, 1'b0);
    go(DASU_OP_STORE_RND, 1'b0, 16'h0000, 1'b0);
    chk("rounded", 40'h0001, 40'(st_data));
    go(DASU_OP_LOAD, 1'b0, 16'h8000, 1'b0);
    shift_src(1'b0, 6'h04, 16'h0005);
    go(DASU_OP_SHIFT, 1'b0, 16'h0000, 1'b0);
    chk("acc first", 40'hFFF8000000, acc1);
    $display("Test shift done");
  endtask : t_shift

  task automatic t_exponent();
    logic [15:0] w [15] = '{16'h0001, 16'h0002, 16'h0004, 16'h0100, 16'h01FF, 16'h0806,
      16'h2007, 16'h4800, 16'h7000, 16'h8000, 16'h900A, 16'hE001, 16'hFF07, 16'h0000, 16'hFFFF};
    logic [4:0] e [15] = '{5'h12, 5'h13, 5'h14, 5'h1A, 5'h1A, 5'h1D, 5'h1F, 5'h00, 5'h00,
      5'h00, 5'h00, 5'h1E, 5'h19, 5'h11, 5'h11};
    for (int k = 0; k < 15; k++) begin
      go(DASU_OP_FIND_CHANGE, 1'b0, w[k], 1'b0);
      chk("exponent", 40'(e[k]), 40'(expo));
      chk("exp valid", 40'h1, 40'(e_vld));
    end
    @(posedge i_clk);
    i_exp_byte <= 1'b1;
    go(DASU_OP_FIND_CHANGE, 1'b0, 16'hFF03, 1'b0);
    chk("byte exponent", 40'h1B, 40'(expo));
    go(DASU_OP_FIND_CHANGE, 1'b0, 16'h00FF, 1'b0);
    chk("byte exponent", 40'h19, 40'(expo));
    $display("Test exponent done");
  endtask : t_exponent

  task automatic t_multiply();
    logic [15:0] cc [6] = '{16'h2000, 16'h2000, 16'h2000, 16'h2000, 16'h0000, 16'h1000};
    logic [3:0]  ai [6] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h4, 4'h5};
    logic [3:0]  bi [6] = '{4'h5, 4'h7, 4'h4, 4'h6, 4'h6, 4'h7};
    logic [31:0] ep [6] = '{32'hFFFF0001, 32'h00008000, 32'hFFFE0001, 32'h80008000,
      32'h00000001, 32'h7FFF8000};
    for (int k = 4; k < 8; k++) begin
      @(posedge i_clk);
      wr_en <= 1'b1;
      wr_idx <= 4'(k);
      wr_data <= (k == 7) ? 16'h8000 : 16'hFFFF;
    end
    @(posedge i_clk);
    wr_en <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      @(posedge i_clk);
      i_core_control_reg <= cc[k];
      i_mul_a_idx <= ai[k];
      i_mul_b_idx <= bi[k];
      go(DASU_OP_INT_MUL, 1'b0, 16'h0000, 1'b0);
      chk("product", 40'(ep[k]), 40'(prod));
      chk("mul valid", 40'h1, 40'(m_vld));
    end
    @(posedge i_clk);
    i_core_control_reg <= 16'h2000;
    i_mul_a_idx <= 4'h6;
    i_mul_b_idx <= 4'h4;
    i_mul_to_acc <= 1'b1;
    go(DASU_OP_INT_MUL, 1'b1, 16'h0000, 1'b0);
    chk("acc second", 40'h00FFFE0001, acc2);
    chk("mul valid", 40'h0, 40'(m_vld));
    // The multiply-to-accumulator code follows the same sign mode path
    go(DASU_OP_MUL_TO_ACC, 1'b0, 16'h0000, 1'b0);
    chk("acc first", 40'h00FFFE0001, acc1);
    $display("Test multiply done");
  endtask : t_multiply

  // Enable low must freeze a pending request and hold the last valid pulse
  task automatic t_freeze();
    go(DASU_OP_STORE, 1'b1, 16'h0000, 1'b1);
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_op <= DASU_OP_NEGATE;
    repeat (2) @(posedge i_clk);
    #1;
    chk("acc second", 40'h00FFFE0001, acc2);
    chk("store data", 40'hFFFE, 40'(st_data));
    chk("store valid", 40'h1, 40'(st_vld));
    @(posedge i_clk);
    i_ce <= 1'b1;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    #1;
    chk("acc second", 40'h0 - 40'h00FFFE0001, acc2);
    chk("store valid", 40'h0, 40'(st_vld));
    $display("Test freeze done");
  endtask : t_freeze

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    end_sim();
  end

  // Reset, then every scenario in turn
  initial begin
    {i_rst, i_ce} = 2'b11;
    {i_op_valid, i_acc_sel, i_shift_use_reg, i_exp_byte, i_mul_to_acc, wr_en} = 6'h00;
    i_op = DASU_OP_NOP;
    {i_word, i_shift_reg, i_core_control_reg, wr_data} = 64'h0;
    {i_shift_lit, i_mul_a_idx, i_mul_b_idx, wr_idx} = 18'h0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    t_load_store();
    t_arith();
    t_shift();
    t_exponent();
    t_multiply();
    t_freeze();
    end_sim();
  end
endmodule : dasu_top_tb
